//--- hdl/scr_pkg.sv
// Constants for the synthesizer configuration register bank: latch codes,
// field positions, reset values and pin synchroniser depth.
// Assumes a single 25 MHz clock and a host on the three-wire serial port.
// How it works
// - Code 000 loads the integer/numerator word
// - Code 001 loads prescaler/phase/denominator word
// - Code 010 loads noise/mux/reference word
// - Code 011 loads the clock-divider word
// - Code 100 loads the output configuration word
// - Code 101 loads the miscellaneous configuration word
// - Integer divide value is bits 30:15
// - Numerator bits 14:3; host keeps below denominator
// - Prescaler select is bit 27
// - Phase word bits 26:15; host keeps below denominator
// - Fraction denominator is bits 14:3
// - Noise mode is bits 30:29
// - Dither on in low spur, off otherwise
// - Test output select is bits 28:26
// - Shadowed fields apply on next integer write
// - Divider select shadowed only while bit 13 high
// - Output divider ratio is bits 22:20
package scr_pkg;

   // Latch select codes in the three low bits
   localparam logic [2:0] LATCH_INT    = 3'h0;
   localparam logic [2:0] LATCH_PHASE  = 3'h1;
   localparam logic [2:0] LATCH_CONFIG = 3'h2;
   localparam logic [2:0] LATCH_CLKDIV = 3'h3;
   localparam logic [2:0] LATCH_OUTPUT = 3'h4;
   localparam logic [2:0] LATCH_MISC   = 3'h5;
   localparam int         LATCH_COUNT  = 6;
   localparam int         WORD_W       = 32;
   localparam int         CODE_W       = 3;

   // Integer/numerator word
   localparam int INT_LSB   = 15;
   localparam int INT_W     = 16;
   localparam int NUM_LSB   = 3;
   localparam int NUM_W     = 12;
   // Prescaler/phase/denominator word
   localparam int PRE_BIT   = 27;
   localparam int PHASE_LSB = 15;
   localparam int PHASE_W   = 12;
   localparam int DEN_LSB   = 3;
   localparam int DEN_W     = 12;
   // Noise/mux/reference word
   localparam int NOISE_LSB = 29;
   localparam int NOISE_W   = 2;
   localparam int TSEL_LSB  = 26;
   localparam int TSEL_W    = 3;
   localparam int DBL_BIT   = 25;
   localparam int REFDIV_BIT = 24;
   localparam int RCNT_LSB  = 14;
   localparam int RCNT_W    = 10;
   localparam int SHDIV_BIT = 13;
   localparam int CP_LSB    = 9;
   localparam int CP_W      = 3;
   localparam int LOCK_CYC_BIT = 8;
   localparam int LOCK_WIN_BIT = 7;
   localparam int PD_BIT    = 5;
   localparam int CP3S_BIT  = 4;
   localparam int CRST_BIT  = 3;
   // Clock-divider word
   localparam int BOOST_BIT = 18;
   localparam int CDM_LSB   = 15;
   localparam int CDM_W     = 2;
   localparam int CDV_LSB   = 3;
   localparam int CDV_W     = 12;
   // Output configuration word
   localparam int FB_BIT    = 23;
   localparam int DIV_LSB   = 20;
   localparam int DIV_W     = 3;
   localparam int MUTE_BIT  = 10;
   localparam int RFEN_BIT  = 5;
   localparam int PWR_LSB   = 3;
   localparam int PWR_W     = 2;
   // Miscellaneous word
   localparam int PULSE_LSB  = 30;
   localparam int PULSE_W    = 2;
   localparam int CANCEL_BIT = 29;
   localparam int LDPIN_LSB = 22;
   localparam int LDPIN_W   = 2;

   // Noise mode encoding
   localparam logic [1:0] NOISE_LOW_NOISE = 2'h0;
   localparam logic [1:0] NOISE_LOW_SPUR  = 2'h3;

   // Reset value of every latch image and field
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // Flip-flops between a pin and the logic that reads it
   localparam int SYNC_STAGES = 2;

endpackage

//--- hdl/scr_config_bank.sv
// Configuration register bank of a fractional-N synthesizer, loaded over a
// three-wire serial port (serial clock, data, latch enable).
// Assumes the serial pins are asynchronous to clk; each pin level must stand
// for at least three clk periods so the oversampled edges are seen.
`timescale 1ns/1ps
module scr_config_bank (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Serial programming pins
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        latch_enable,
   // Load indication, one-hot per latch code
   output logic [5:0]       latch_loaded,
   // Integer/numerator fields
   output logic [15:0]      integer_value,
   output logic [11:0]      numerator_value,
   // Prescaler/phase/denominator fields
   output logic             prescaler_select,
   output logic [11:0]      phase_word,
   output logic [11:0]      fraction_denominator,
   // Noise/mux/reference fields
   output logic [1:0]       noise_mode,
   output logic             dither_enable,
   output logic [2:0]       test_output_select,
   output logic             ref_doubler,
   output logic             ref_div2,
   output logic [9:0]       ref_count,
   output logic             conditionally_shadowed_bits,
   output logic [2:0]       cp_current,
   output logic             lock_cycles_select,
   output logic             lock_window_select,
   output logic             power_down,
   output logic             cp_three_state,
   output logic             counter_reset,
   // Clock-divider fields
   output logic             boost_enable,
   output logic [1:0]       clk_div_mode,
   output logic [11:0]      clk_div_value,
   // Output configuration fields
   output logic             feedback_select,
   output logic [2:0]       divider_select,
   output logic             mute_till_lock,
   output logic             rf_out_enable,
   output logic [1:0]       output_power,
   // Miscellaneous fields
   output logic [1:0]       antibacklash_width,
   output logic             charge_cancel,
   output logic [1:0]       lock_pin_mode
);

   localparam int SW = scr_pkg::SYNC_STAGES;

   // Pin synchronisers; last stage kept for edge detection
   logic [SW:0]             sclk_sync;
   logic [SW-1:0]           sdata_sync;
   logic [SW:0]             le_sync;
   logic                    sclk_rise;
   logic                    le_rise;

   // Serial shift register and latched word
   logic [31:0]             shift_word;
   logic [2:0]              latch_select_code;
   logic                    load_int;
   logic                    load_phase;
   logic                    load_config;
   logic                    load_clkdiv;
   logic                    load_output;
   logic                    load_misc;

   // Staged values of shadowed fields, waiting for an integer-word load
   logic [11:0]             stage_phase;
   logic [11:0]             stage_den;
   logic                    stage_doubler;
   logic                    stage_div2;
   logic [9:0]              stage_rcount;
   logic [2:0]              stage_cp;
   logic [2:0]              stage_divider;
   logic                    shadowed_register_mark;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_sync  <= '0;
         sdata_sync <= '0;
         le_sync    <= '0;
      end else begin
         sclk_sync  <= {sclk_sync[SW-1:0], ser_clk};
         sdata_sync <= {sdata_sync[SW-2:0], ser_data};
         le_sync    <= {le_sync[SW-1:0], latch_enable};
      end
   end

   assign sclk_rise = sclk_sync[SW-1] & ~sclk_sync[SW];
   assign le_rise   = le_sync[SW-1] & ~le_sync[SW];

   // Data is taken most significant bit first on each serial clock rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_word <= scr_pkg::WORD_RESET;
      end else if (sclk_rise) begin
         shift_word <= {shift_word[30:0], sdata_sync[SW-1]};
      end
   end

   // Unused codes 110 and 111 load nothing
   assign latch_select_code = shift_word[scr_pkg::CODE_W-1:0];
   assign load_int    = le_rise && (latch_select_code == scr_pkg::LATCH_INT);
   assign load_phase  = le_rise && (latch_select_code == scr_pkg::LATCH_PHASE);
   assign load_config = le_rise && (latch_select_code == scr_pkg::LATCH_CONFIG);
   assign load_clkdiv = le_rise && (latch_select_code == scr_pkg::LATCH_CLKDIV);
   assign load_output = le_rise && (latch_select_code == scr_pkg::LATCH_OUTPUT);
   assign load_misc   = le_rise && (latch_select_code == scr_pkg::LATCH_MISC);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_loaded <= '0;
      end else begin
         latch_loaded <= {load_misc, load_output, load_clkdiv,
                          load_config, load_phase, load_int};
      end
   end

   // Integer word; its load also releases every staged shadowed value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         integer_value   <= '0;
         numerator_value <= '0;
      end else if (load_int) begin
         integer_value   <= shift_word[scr_pkg::INT_LSB +: scr_pkg::INT_W];
         numerator_value <= shift_word[scr_pkg::NUM_LSB +: scr_pkg::NUM_W];
      end
   end

   // Prescaler takes effect at once; phase and denominator are staged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prescaler_select <= 1'b0;
         stage_phase      <= '0;
         stage_den        <= '0;
      end else if (load_phase) begin
         prescaler_select <= shift_word[scr_pkg::PRE_BIT];
         stage_phase      <= shift_word[scr_pkg::PHASE_LSB +: scr_pkg::PHASE_W];
         stage_den        <= shift_word[scr_pkg::DEN_LSB +: scr_pkg::DEN_W];
      end
   end

   // Reference and charge pump current fields are staged, the rest is immediate
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         noise_mode                  <= scr_pkg::NOISE_LOW_NOISE;
         dither_enable               <= 1'b0;
         test_output_select          <= '0;
         stage_doubler               <= 1'b0;
         stage_div2                  <= 1'b0;
         stage_rcount                <= '0;
         conditionally_shadowed_bits <= 1'b0;
         stage_cp                    <= '0;
         lock_cycles_select          <= 1'b0;
         lock_window_select          <= 1'b0;
         power_down                  <= 1'b0;
         cp_three_state              <= 1'b0;
         counter_reset               <= 1'b0;
      end else if (load_config) begin
         noise_mode         <= shift_word[scr_pkg::NOISE_LSB +: scr_pkg::NOISE_W];
         dither_enable      <= (shift_word[scr_pkg::NOISE_LSB +: scr_pkg::NOISE_W]
                                == scr_pkg::NOISE_LOW_SPUR);
         test_output_select <= shift_word[scr_pkg::TSEL_LSB +: scr_pkg::TSEL_W];
         stage_doubler      <= shift_word[scr_pkg::DBL_BIT];
         stage_div2         <= shift_word[scr_pkg::REFDIV_BIT];
         stage_rcount       <= shift_word[scr_pkg::RCNT_LSB +: scr_pkg::RCNT_W];
         conditionally_shadowed_bits <= shift_word[scr_pkg::SHDIV_BIT];
         stage_cp           <= shift_word[scr_pkg::CP_LSB +: scr_pkg::CP_W];
         lock_cycles_select <= shift_word[scr_pkg::LOCK_CYC_BIT];
         lock_window_select <= shift_word[scr_pkg::LOCK_WIN_BIT];
         power_down         <= shift_word[scr_pkg::PD_BIT];
         cp_three_state     <= shift_word[scr_pkg::CP3S_BIT];
         counter_reset      <= shift_word[scr_pkg::CRST_BIT];
      end
   end

   // Staged values move to the active fields on an integer-word load.
   // All six use the staged copy as it stood before this edge, so a shadowed
   // field written later waits for the following integer-word load.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_word           <= '0;
         fraction_denominator <= '0;
         ref_doubler          <= 1'b0;
         ref_div2             <= 1'b0;
         ref_count            <= '0;
         cp_current           <= '0;
      end else if (load_int) begin
         phase_word           <= stage_phase;
         fraction_denominator <= stage_den;
         ref_doubler          <= stage_doubler;
         ref_div2             <= stage_div2;
         ref_count            <= stage_rcount;
         cp_current           <= stage_cp;
      end
   end

   // Clock-divider word, all immediate
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boost_enable  <= 1'b0;
         clk_div_mode  <= '0;
         clk_div_value <= '0;
      end else if (load_clkdiv) begin
         boost_enable  <= shift_word[scr_pkg::BOOST_BIT];
         clk_div_mode  <= shift_word[scr_pkg::CDM_LSB +: scr_pkg::CDM_W];
         clk_div_value <= shift_word[scr_pkg::CDV_LSB +: scr_pkg::CDV_W];
      end
   end

   // Output configuration word except the divider select
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         feedback_select <= 1'b0;
         mute_till_lock  <= 1'b0;
         rf_out_enable   <= 1'b0;
         output_power    <= '0;
      end else if (load_output) begin
         feedback_select <= shift_word[scr_pkg::FB_BIT];
         mute_till_lock  <= shift_word[scr_pkg::MUTE_BIT];
         rf_out_enable   <= shift_word[scr_pkg::RFEN_BIT];
         output_power    <= shift_word[scr_pkg::PWR_LSB +: scr_pkg::PWR_W];
      end
   end

   // Divider select: staged while shadowing is on, otherwise applied at once.
   // A pending staged value still waits for the integer-word load even if
   // shadowing is switched off meanwhile, so nothing is applied early.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage_divider          <= '0;
         shadowed_register_mark <= 1'b0;
         divider_select         <= '0;
      end else begin
         if (load_output && conditionally_shadowed_bits) begin
            stage_divider          <= shift_word[scr_pkg::DIV_LSB +: scr_pkg::DIV_W];
            shadowed_register_mark <= 1'b1;
         end else if (load_output) begin
            divider_select         <= shift_word[scr_pkg::DIV_LSB +: scr_pkg::DIV_W];
            shadowed_register_mark <= 1'b0;
         end else if (load_int && shadowed_register_mark) begin
            divider_select         <= stage_divider;
            shadowed_register_mark <= 1'b0;
         end
      end
   end

   // Miscellaneous word; other positions are reserved and ignored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         antibacklash_width <= '0;
         charge_cancel      <= 1'b0;
         lock_pin_mode      <= '0;
      end else if (load_misc) begin
         antibacklash_width <= shift_word[scr_pkg::PULSE_LSB +: scr_pkg::PULSE_W];
         charge_cancel      <= shift_word[scr_pkg::CANCEL_BIT];
         lock_pin_mode      <= shift_word[scr_pkg::LDPIN_LSB +: scr_pkg::LDPIN_W];
      end
   end

endmodule

//--- tb/scr_config_bank_chk.sv
// Assertions for the synthesizer register bank: a change of each observed field but dither_enable is tied
// to the load pulse that applies it; dither_enable is checked against noise_mode. Sees only the bank's ports.
`timescale 1ns/1ps
module scr_config_bank_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Observed outputs
   input wire logic [5:0]  latch_loaded,
   input wire logic [15:0] integer_value,
   input wire logic [11:0] numerator_value,
   input wire logic        prescaler_select,
   input wire logic [11:0] phase_word,
   input wire logic [11:0] fraction_denominator,
   input wire logic [1:0]  noise_mode,
   input wire logic        dither_enable,
   input wire logic [2:0]  test_output_select,
   input wire logic        conditionally_shadowed_bits,
   input wire logic [11:0] clk_div_value,
   input wire logic [2:0]  divider_select,
   input wire logic [1:0]  lock_pin_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_load_onehot: assert property ($onehot0(latch_loaded))
      else $error("two latches loaded at once");
   a_pulse_single: assert property (|latch_loaded |=> latch_loaded == 6'h00)
      else $error("load pulse longer than one cycle");
   a_int_source: assert property (
      $changed({integer_value, numerator_value}) |-> latch_loaded[0])
      else $error("integer word changed without its load");
   a_presc_source: assert property ($changed(prescaler_select) |-> latch_loaded[1])
      else $error("prescaler changed without its load");
   a_shadow_apply: assert property (
      $changed({phase_word, fraction_denominator}) |-> latch_loaded[0])
      else $error("shadowed field applied outside integer load");
   a_dither_mode: assert property (
      dither_enable == (noise_mode == scr_pkg::NOISE_LOW_SPUR))
      else $error("dither disagrees with noise mode");
   a_noise_source: assert property (
      $changed({noise_mode, test_output_select, conditionally_shadowed_bits})
      |-> latch_loaded[2])
      else $error("noise word changed without its load");
   a_clkdiv_source: assert property ($changed(clk_div_value) |-> latch_loaded[3])
      else $error("clock divider changed without its load");
   a_div_source: assert property ($changed(divider_select) |->
      latch_loaded[0] || (latch_loaded[4] && !conditionally_shadowed_bits))
      else $error("divider select applied at wrong load");
   a_misc_source: assert property ($changed(lock_pin_mode) |-> latch_loaded[5])
      else $error("misc word changed without its load");
endmodule

bind scr_config_bank scr_config_bank_chk u_chk (
   .clk(clk), .rst(rst), .latch_loaded(latch_loaded), .integer_value(integer_value),
   .numerator_value(numerator_value), .prescaler_select(prescaler_select),
   .phase_word(phase_word), .fraction_denominator(fraction_denominator),
   .noise_mode(noise_mode), .dither_enable(dither_enable),
   .test_output_select(test_output_select),
   .conditionally_shadowed_bits(conditionally_shadowed_bits),
   .clk_div_value(clk_div_value), .divider_select(divider_select),
   .lock_pin_mode(lock_pin_mode));

//--- tb/scr_host_model.sv
// Host side of the three-wire programming port: shifts a word MSB first and
// then pulses the latch pin. Assumes the bank oversamples the pins with clk.
`timescale 1ns/1ps
module scr_host_model (
   // Clock
   input wire logic clk,
   // Serial programming pins
   output logic     ser_clk,
   output logic     ser_data,
   output logic     latch_enable
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_enable = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Each level stands half cycles; under three the bank may miss an edge
   task automatic send_word(input logic [31:0] w, input int half);
      for (int i = 31; i >= 0; i--) begin
         ser_data = w[i];
         hold(half);
         ser_clk = 1'b1;
         hold(half);
         ser_clk = 1'b0;
      end
      hold(half);
      latch_enable = 1'b1;
      hold(half);
      latch_enable = 1'b0;
      // Hold time over: a stale level must not be trusted
      ser_data = ~w[0];
   endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the register bank: random words for each latch,
// refused codes, shadowed fields. Assumes scr_host_model drives the pins.
`timescale 1ns/1ps
module testbench;
   logic        clk, rst, ser_clk, ser_data, latch_enable;
   logic [5:0]  latch_loaded, seen;
   logic [15:0] integer_value;
   logic [11:0] numerator_value, phase_word, fraction_denominator, clk_div_value;
   logic [9:0]  ref_count;
   logic [2:0]  test_output_select, divider_select, cp_current, e_div = '0, p_div = '0;
   logic [1:0]  noise_mode, lock_pin_mode, clk_div_mode, output_power, antibacklash_width;
   logic        prescaler_select, dither_enable, conditionally_shadowed_bits, ref_doubler;
   logic        ref_div2, lock_cycles_select, lock_window_select, power_down, cp_three_state;
   logic        counter_reset, boost_enable, feedback_select, mute_till_lock, rf_out_enable;
   logic        charge_cancel, p_v = 1'b0;
   // Last word per latch code; a1 and a2 hold words 1 and 2 as the last word 0 applied them
   logic [31:0] w0 = '0, w1 = '0, w2 = '0, w3 = '0, w4 = '0, w5 = '0, a1 = '0, a2 = '0;
   // Mux code standing for the lock detect source; the value is arbitrary
   localparam logic [2:0] TSEL_LOCK = 3'h6;
   integer      seed = 78, miscompares = 0, samples_checked = 0;

   scr_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
      .latch_enable(latch_enable));
   scr_config_bank uut (.clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
      .latch_enable(latch_enable), .latch_loaded(latch_loaded),
      .integer_value(integer_value), .numerator_value(numerator_value),
      .prescaler_select(prescaler_select), .phase_word(phase_word),
      .fraction_denominator(fraction_denominator), .noise_mode(noise_mode),
      .dither_enable(dither_enable), .test_output_select(test_output_select),
      .ref_doubler(ref_doubler), .ref_div2(ref_div2), .ref_count(ref_count),
      .conditionally_shadowed_bits(conditionally_shadowed_bits), .cp_current(cp_current),
      .lock_cycles_select(lock_cycles_select), .lock_window_select(lock_window_select),
      .power_down(power_down), .cp_three_state(cp_three_state),
      .counter_reset(counter_reset), .boost_enable(boost_enable),
      .clk_div_mode(clk_div_mode), .clk_div_value(clk_div_value),
      .feedback_select(feedback_select), .divider_select(divider_select),
      .mute_till_lock(mute_till_lock), .rf_out_enable(rf_out_enable),
      .output_power(output_power), .antibacklash_width(antibacklash_width),
      .charge_cancel(charge_cancel), .lock_pin_mode(lock_pin_mode));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pulses last one cycle, so collect them for the waiting task
   always @(posedge clk) seen <= seen | latch_loaded;

   // Reserved bits stay random: the bank must ignore them
   function automatic logic [31:0] build(input logic [2:0] code, input int i);
      logic [31:0] w;
      w = $random(seed);
      if (code == 3'h0) begin
         w[30:15] = 16'h8000 | w[30:15];
         w[14:3] = w[14:3] % w1[14:3];
      end else if (code == 3'h1) begin
         w[27] = 1'b1;
         w[14:3] = w[14:3] | 12'h800;
         w[26:15] = i[0] ? 12'h001 : w[14:3] - 12'h001;
      end else if (code == 3'h2) begin
         w[30:29] = i[1:0];
         w[13] = i[2];
         if (i[0]) w[28:26] = TSEL_LOCK;
      end
      w[2:0] = code;
      return w;
   endfunction

   function automatic void model(input logic [31:0] w);
      case (w[2:0])
         3'h0: begin
            {w0, a1, a2} = {w, w1, w2};
            if (p_v) e_div = p_div;
            p_v = 1'b0;
         end
         3'h1: w1 = w;
         3'h2: w2 = w;
         3'h3: w3 = w;
         3'h4: begin
            w4 = w;
            if (w2[13]) {p_div, p_v} = {w[22:20], 1'b1};
            else {e_div, p_v} = {w[22:20], 1'b0};
         end
         3'h5: w5 = w;
         default: ;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_all;
      chk({integer_value, numerator_value}, {w0[30:15], w0[14:3]}, "int word");
      chk(prescaler_select, w1[27], "prescaler");
      chk({phase_word, fraction_denominator}, {a1[26:15], a1[14:3]}, "phase/den");
      chk({noise_mode, test_output_select}, w2[30:26], "noise/mux");
      chk(dither_enable, w2[30:29] == scr_pkg::NOISE_LOW_SPUR, "dither");
      chk({conditionally_shadowed_bits, lock_cycles_select, lock_window_select,
           power_down, cp_three_state, counter_reset}, {w2[13], w2[8:7], w2[5:3]}, "word 2");
      chk({ref_doubler, ref_div2, ref_count, cp_current}, {a2[25:14], a2[11:9]}, "ref");
      chk({boost_enable, clk_div_mode, clk_div_value}, {w3[18], w3[16:3]}, "word 3");
      chk({feedback_select, divider_select}, {w4[23], e_div}, "divider");
      chk({mute_till_lock, rf_out_enable, output_power}, {w4[10], w4[5:3]}, "word 4");
      chk({charge_cancel, lock_pin_mode}, {w5[29], w5[23:22]}, "word 5");
      chk(antibacklash_width, w5[31:30], "pulse width");
   endtask

   task automatic end_sim;
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic do_word(input logic [2:0] code, input int i);
      logic [31:0] w;
      int n;
      w = build(code, i);
      seen = 6'h00;
      host.send_word(w, 3 + 2 * (i % 2));
      n = 0;
      while (seen == 6'h00 && n < 12) begin
         @(posedge clk);
         #1;
         n++;
      end
      model(w);
      chk(seen, (code < 3'h6) ? (6'h01 << code) : 6'h00, "load pulse");
      check_all();
      if (code < 3'h6 && seen == 6'h00) end_sim();
   endtask

   initial begin
      rst = 1'b1;
      seen = 6'h00;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      check_all();
      for (int i = 0; i < 8; i++) begin
         do_word(3'h2, i);
         do_word(3'h1, i);
         do_word(3'h4, i);
         do_word(3'h3, i);
         do_word(3'h5, i);
         do_word(3'h0, i);
         do_word(3'h6, i);
         do_word(3'h7, i);
      end
      end_sim();
   end
endmodule
